/* core/hsl_blink.sv */
`timescale 1ns/1ps
module hsl_blink
	import hsl_pkg::*;
#(
	parameter int unsigned PERIOD   = PERIOD_CYC,
	parameter int unsigned SHORT_ON = SHORT_ON_CYC,
	parameter int unsigned LONG_ON  = LONG_ON_CYC
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	hsl_blink_if.gen  bl
);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);
	localparam logic [CNT_W-1:0] SH_C = CNT_W'(SHORT_ON);
	localparam logic [CNT_W-1:0] LG_C = CNT_W'(LONG_ON);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             sh;
		logic             lg;
	} hsl_blink_s;

	hsl_blink_s st_reg;
	hsl_blink_s st_next;

	// Both patterns share one period so a switch between them never shows a stray pulse.
	always_comb begin
		st_next     = st_reg;
		st_next.cnt = (st_reg.cnt == LAST) ? '0 : st_reg.cnt + 1'b1;
		st_next.sh  = st_reg.cnt < SH_C;
		st_next.lg  = st_reg.cnt < LG_C;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bl.short_on = st_reg.sh;
	assign bl.long_on  = st_reg.lg;

	a_blink_nested: assert property (@(posedge clk_i) disable iff (rst_i)
		st_reg.sh |-> st_reg.lg)
		else $error("Short blink lit while long blink dark.");
endmodule

/* core/hsl_blink_if.sv */
`timescale 1ns/1ps
// Carries the two blink patterns from the generator to the lamp logic.
interface hsl_blink_if;
	logic short_on;
	logic long_on;
	modport gen  (output short_on, output long_on);
	modport sink (input short_on, input long_on);
endinterface

/* core/hsl_pkg.sv */
package hsl_pkg;

	// ------------------------------------------------------------------
	// Timing of the removal lamp blink patterns.
	// ------------------------------------------------------------------
	// Clock rate in kHz, which is also the number of cycles per millisecond.
	localparam int unsigned CLK_KHZ         = 250000;
	localparam int unsigned BLINK_PERIOD_MS = 1000;
	localparam int unsigned SHORT_ON_MS     = 100;
	localparam int unsigned LONG_ON_MS      = 900;
	localparam int unsigned PERIOD_CYC      = BLINK_PERIOD_MS * CLK_KHZ;
	localparam int unsigned SHORT_ON_CYC    = SHORT_ON_MS * CLK_KHZ;
	localparam int unsigned LONG_ON_CYC     = LONG_ON_MS * CLK_KHZ;
	localparam int          CNT_W           = 28;

	// Number of optical cage link lamps: two quad cages, two plus cages, one plain cage.
	localparam int LINK_N = 5;

	// ------------------------------------------------------------------
	// Register offsets, field positions and reset values.
	// ------------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_CMD  = 8'h04;
	localparam logic [7:0] ADR_STAT = 8'h08;
	localparam logic [7:0] ADR_EVT  = 8'h0C;
	localparam logic [7:0] ADR_LAMP = 8'h10;
	localparam logic [7:0] ADR_LINK = 8'h14;
	localparam logic [7:0] ADR_INFO = 8'h18;

	localparam int CTRL_FWUP_BIT   = 0;
	localparam int CTRL_BOOTUP_BIT = 1;
	localparam int CMD_ACT_BIT     = 0;
	localparam int CMD_QUIES_BIT   = 1;
	localparam int CMD_REJ_BIT     = 2;
	localparam int EVT_OPEN_BIT    = 0;
	localparam int EVT_QUIES_BIT   = 1;
	localparam int LAMP_REM_LSB    = 0;
	localparam int LAMP_OOS_LSB    = 4;
	localparam int LAMP_HLT_LSB    = 8;
	localparam int LINK_VAL_LSB    = 8;

	localparam logic [1:0]  CTRL_RST = 2'h0;
	localparam logic [11:0] LAMP_RST = 12'h000;
	localparam logic [12:0] LINK_RST = 13'h0000;

	// Lamp override modes; mode zero leaves the lamp to the hardware.
	localparam logic [2:0] LM_AUTO  = 3'h0;
	localparam logic [2:0] LM_OFF   = 3'h1;
	localparam logic [2:0] LM_ON    = 3'h2;
	localparam logic [2:0] LM_SHORT = 3'h3;
	localparam logic [2:0] LM_LONG  = 3'h4;
	localparam logic [2:0] LM_AMBER = 3'h5;

	// Current draw in tenths of an ampere on the 12 V rail: one ampere.
	localparam logic [7:0] CUR_DRAW = 8'h0A;

	typedef enum logic [2:0] {HS_M1, HS_M2, HS_M4, HS_M5, HS_M6} hsl_hs_e;
	typedef enum logic [2:0] {BT_TEST, BT_SUM, BT_FLAG, BT_RUN, BT_FAIL} hsl_boot_e;

endpackage

/* core/hsl_sync.sv */
`timescale 1ns/1ps
module hsl_sync #(
	parameter int           W    = 8,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} hsl_sync_s;

	hsl_sync_s st_reg;
	hsl_sync_s st_next;

	// A bit changes only once the second and third stages agree, which also rejects glitches.
	always_comb begin
		st_next    = st_reg;
		st_next.s1 = d_i;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		st_next.q  = (st_reg.s2 & st_reg.s3) | (st_reg.q & (st_reg.s2 | st_reg.s3));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= {INIT, INIT, INIT, INIT};
		end else begin
			st_reg <= st_next;
		end
	end

	assign q_o = st_reg.q;

	a_sync_agree: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_reg.s2 == st_reg.s3) |=> (st_reg.q == $past(st_reg.s2)))
		else $error("Filtered pin did not follow agreeing stages.");
endmodule

/* core/hsl_top.sv */
`timescale 1ns/1ps
module hsl_top
	import hsl_pkg::*;
#(
	parameter int unsigned PERIOD_CYC_P   = PERIOD_CYC,
	parameter int unsigned SHORT_ON_CYC_P = SHORT_ON_CYC,
	parameter int unsigned LONG_ON_CYC_P  = LONG_ON_CYC,
	parameter logic [23:0] MFG_ID_P       = 24'hA1B2C3 // Arbitrary value.
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              handle_switch_n_i,
	input  wire logic              payload_pgood_i,
	input  wire logic              sensor_fault_i,
	input  wire logic [LINK_N-1:0] link_up_i,
	input  wire logic              selftest_ok_i,
	input  wire logic              code_valid_i,
	input  wire logic [7:0]        code_data_i,
	input  wire logic              code_last_i,
	output logic                   payload_en_o,
	output logic                   mgmt_rst_o,
	output logic                   op_flag_o,
	output logic                   run_op_o,
	output logic                   event_pend_o,
	output logic                   removal_lamp_o,
	output logic                   out_of_service_lamp_o,
	output logic                   health_green_o,
	output logic                   health_amber_o,
	output logic      [LINK_N-1:0] link_lamp_o
);

	// ------------------------------------------------------------------
	// State of the block.
	// ------------------------------------------------------------------
	typedef struct packed {
		hsl_hs_e           hs;
		hsl_boot_e         boot;
		logic [7:0]        sum;
		logic              sum_ok;
		logic              op_flag;
		logic              run_op;
		logic [1:0]        ctrl;
		logic [1:0]        evt;
		logic [11:0]       lamp;
		logic [12:0]       link;
		logic              hdl_prev;
		logic              payload_en;
		logic              ack;
		logic [31:0]       dat;
		logic              rem_lamp;
		logic              oos_lamp;
		logic              hlt_g;
		logic              hlt_a;
		logic [LINK_N-1:0] link_lamp;
		logic              evt_pend;
	} hsl_top_s;

	hsl_top_s st_reg;
	hsl_top_s st_next;

	// ------------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------------
	// Byte-lane merge of a register write.
	function automatic logic [31:0] wmerge(input logic [31:0] old,
	                                       input logic [31:0] din,
	                                       input logic [3:0]  sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = din[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Resolves an override mode against the automatic value of a lamp.
	function automatic logic lamp_pick(input logic [2:0] mode, input logic auto_v,
	                                   input logic sh, input logic lg);
		logic res;
		res = auto_v;
		case (mode)
			LM_OFF:   res = 1'b0;
			LM_ON:    res = 1'b1;
			LM_SHORT: res = sh;
			LM_LONG:  res = lg;
			default:  res = auto_v;
		endcase
		return res;
	endfunction

	// Reports the hot-swap state as its M number.
	function automatic logic [2:0] hs_code(input hsl_hs_e hs);
		logic [2:0] res;
		res = 3'h1;
		case (hs)
			HS_M2:   res = 3'h2;
			HS_M4:   res = 3'h4;
			HS_M5:   res = 3'h5;
			HS_M6:   res = 3'h6;
			default: res = 3'h1;
		endcase
		return res;
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers and blink generator.
	// ------------------------------------------------------------------
	logic [LINK_N+2:0] pin_q;
	logic              hdl;
	logic              pgood;
	logic              fault;
	logic [LINK_N-1:0] link_q;

	// The latch switch resets to released so that reset itself is no handle event.
	hsl_sync #(
		.W    (LINK_N + 3),
		.INIT ((LINK_N + 3)'(1))
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({link_up_i, sensor_fault_i, payload_pgood_i, handle_switch_n_i}),
		.q_o   (pin_q)
	);

	assign hdl    = pin_q[0];
	assign pgood  = pin_q[1];
	assign fault  = pin_q[2];
	assign link_q = pin_q[LINK_N+2:3];

	hsl_blink_if bl();

	hsl_blink #(
		.PERIOD   (PERIOD_CYC_P),
		.SHORT_ON (SHORT_ON_CYC_P),
		.LONG_ON  (LONG_ON_CYC_P)
	) u_blink (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.bl    (bl)
	);

	// ------------------------------------------------------------------
	// Bus decode.
	// ------------------------------------------------------------------
	// One access per cycle pair: ack drops in the cycle after it was given.
	logic       req;
	logic       wr;
	logic       cmd_act;
	logic       cmd_quies;
	logic       cmd_rej;
	logic [1:0] evt_clr;

	assign req       = wb_cyc_i & wb_stb_i & ~st_reg.ack;
	assign wr        = req & wb_we_i;
	assign cmd_act   = wr & (wb_adr_i == ADR_CMD) & wb_sel_i[0] & wb_dat_i[CMD_ACT_BIT];
	assign cmd_quies = wr & (wb_adr_i == ADR_CMD) & wb_sel_i[0] & wb_dat_i[CMD_QUIES_BIT];
	assign cmd_rej   = wr & (wb_adr_i == ADR_CMD) & wb_sel_i[0] & wb_dat_i[CMD_REJ_BIT];
	assign evt_clr   = (wr && wb_adr_i == ADR_EVT && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;

	// ------------------------------------------------------------------
	// Next-state logic.
	// ------------------------------------------------------------------
	always_comb begin
		logic [31:0] wv;
		logic [1:0]  es;
		logic        rem_auto;
		wv       = 32'h0;
		es       = 2'h0;
		rem_auto = 1'b1;
		st_next  = st_reg;

		// Register access; unmapped offsets answer with zero and ignore writes.
		st_next.ack = req;
		if (req) begin
			case (wb_adr_i)
				ADR_CTRL: st_next.dat = 32'(st_reg.ctrl);
				ADR_STAT: st_next.dat = {23'h0, fault, ~hdl, st_reg.boot == BT_FAIL,
				                         st_reg.run_op, st_reg.op_flag, st_reg.payload_en,
				                         hs_code(st_reg.hs)};
				ADR_EVT:  st_next.dat = 32'(st_reg.evt);
				ADR_LAMP: st_next.dat = 32'(st_reg.lamp);
				ADR_LINK: st_next.dat = 32'(st_reg.link);
				ADR_INFO: st_next.dat = {MFG_ID_P, CUR_DRAW};
				default:  st_next.dat = 32'h0;
			endcase
			if (wb_we_i) begin
				case (wb_adr_i)
					ADR_CTRL: begin
						wv           = wmerge(32'(st_reg.ctrl), wb_dat_i, wb_sel_i);
						st_next.ctrl = wv[1:0];
					end
					ADR_LAMP: begin
						wv           = wmerge(32'(st_reg.lamp), wb_dat_i, wb_sel_i);
						st_next.lamp = wv[11:0];
					end
					ADR_LINK: begin
						wv           = wmerge(32'(st_reg.link), wb_dat_i, wb_sel_i);
						st_next.link = wv[12:0];
					end
					default: wv = 32'h0;
				endcase
			end
		end

		// Boot sequence; an upgrade of the boot block pins it at the start.
		if (st_reg.ctrl[CTRL_BOOTUP_BIT]) begin
			st_next.boot    = BT_TEST;
			st_next.op_flag = 1'b0;
			st_next.run_op  = 1'b0;
		end else begin
			case (st_reg.boot)
				BT_TEST: begin
					if (selftest_ok_i) begin
						st_next.boot = BT_SUM;
						st_next.sum  = 8'h00;
					end
				end
				BT_SUM: begin
					if (code_valid_i) begin
						st_next.sum = st_reg.sum + code_data_i;
						if (code_last_i) begin
							st_next.sum_ok = (st_next.sum == 8'h00);
							st_next.boot   = BT_FLAG;
						end
					end
				end
				BT_FLAG: begin
					st_next.op_flag = 1'b1;
					st_next.boot    = st_reg.sum_ok ? BT_RUN : BT_FAIL;
				end
				BT_RUN:  st_next.run_op = 1'b1;
				BT_FAIL: st_next.run_op = 1'b0;
				default: st_next.boot = BT_TEST;
			endcase
		end

		// Hot-swap sequence.
		st_next.hdl_prev = hdl;
		case (st_reg.hs)
			HS_M1: begin
				if (hdl) begin
					st_next.hs = HS_M2;
				end
			end
			HS_M2: begin
				if (!hdl) begin
					st_next.hs = HS_M1;
				end else if (cmd_act) begin
					st_next.hs         = HS_M4;
					st_next.payload_en = 1'b1;
				end
			end
			HS_M4: begin
				if (st_reg.hdl_prev && !hdl) begin
					st_next.hs       = HS_M5;
					es[EVT_OPEN_BIT] = 1'b1;
				end
			end
			HS_M5: begin
				// The front board asks for quiesce only once the shelf manager agreed.
				if (cmd_quies) begin
					st_next.hs = HS_M6;
				end else if (cmd_rej) begin
					st_next.hs = HS_M4;
				end
			end
			HS_M6: begin
				st_next.payload_en = 1'b0;
				// The event waits for the rail to collapse, not only for the enable.
				if (!st_reg.payload_en && !pgood) begin
					st_next.hs        = HS_M1;
					es[EVT_QUIES_BIT] = 1'b1;
				end
			end
			default: st_next.hs = HS_M1;
		endcase

		// Event flags: a new event wins over a clear in the same cycle.
		st_next.evt      = (st_reg.evt & ~evt_clr) | es;
		st_next.evt_pend = |st_next.evt;

		// Removal lamp pattern per hot-swap state.
		case (st_reg.hs)
			HS_M1:   rem_auto = 1'b1;
			HS_M2:   rem_auto = bl.long_on;
			HS_M4:   rem_auto = 1'b0;
			HS_M5:   rem_auto = bl.short_on;
			HS_M6:   rem_auto = bl.short_on;
			default: rem_auto = 1'b1;
		endcase
		st_next.rem_lamp = lamp_pick(st_reg.lamp[LAMP_REM_LSB +: 3], rem_auto,
		                             bl.short_on, bl.long_on);
		st_next.oos_lamp = lamp_pick(st_reg.lamp[LAMP_OOS_LSB +: 3],
		                             st_reg.ctrl[CTRL_FWUP_BIT],
		                             bl.short_on, bl.long_on);

		// Health lamp is two colours, so it has its own override decode.
		case (st_reg.lamp[LAMP_HLT_LSB +: 3])
			LM_OFF: begin
				st_next.hlt_g = 1'b0;
				st_next.hlt_a = 1'b0;
			end
			LM_ON: begin
				st_next.hlt_g = 1'b1;
				st_next.hlt_a = 1'b0;
			end
			LM_AMBER: begin
				st_next.hlt_g = 1'b0;
				st_next.hlt_a = 1'b1;
			end
			default: begin
				st_next.hlt_g = pgood & ~fault;
				st_next.hlt_a = fault;
			end
		endcase

		// Link lamps follow the links unless a per-lamp override is enabled.
		st_next.link_lamp = (st_reg.link[LINK_N-1:0] & st_reg.link[LINK_VAL_LSB +: LINK_N])
		                  | (~st_reg.link[LINK_N-1:0] & link_q);
	end

	// ------------------------------------------------------------------
	// State register.
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg          <= '0;
			st_reg.hs       <= HS_M1;
			st_reg.boot     <= BT_TEST;
			st_reg.ctrl     <= CTRL_RST;
			st_reg.lamp     <= LAMP_RST;
			st_reg.link     <= LINK_RST;
			st_reg.hdl_prev <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// All outputs come straight from the state register.
	assign wb_dat_o              = st_reg.dat;
	assign wb_ack_o              = st_reg.ack;
	assign payload_en_o          = st_reg.payload_en;
	assign mgmt_rst_o            = st_reg.ctrl[CTRL_BOOTUP_BIT];
	assign op_flag_o             = st_reg.op_flag;
	assign run_op_o              = st_reg.run_op;
	assign event_pend_o          = st_reg.evt_pend;
	assign removal_lamp_o        = st_reg.rem_lamp;
	assign out_of_service_lamp_o = st_reg.oos_lamp;
	assign health_green_o        = st_reg.hlt_g;
	assign health_amber_o        = st_reg.hlt_a;
	assign link_lamp_o           = st_reg.link_lamp;

	// ------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic rem_auto_mode;
	assign rem_auto_mode = (st_reg.lamp[LAMP_REM_LSB +: 3] == LM_AUTO);

	sequence s_handle_open;
		st_reg.hs == HS_M4 && st_reg.hdl_prev && !hdl;
	endsequence

	sequence s_quiesce;
		st_reg.hs == HS_M5 && cmd_quies;
	endsequence

	a_lamp_active_off: assert property (st_reg.hs == HS_M4 && rem_auto_mode
		|=> !removal_lamp_o)
		else $error("Removal lamp lit in active state.");

	a_lamp_inactive_on: assert property (st_reg.hs == HS_M1 && rem_auto_mode
		|=> removal_lamp_o)
		else $error("Removal lamp dark in inactive state.");

	a_lamp_short_blink: assert property ((st_reg.hs == HS_M5 || st_reg.hs == HS_M6)
		&& rem_auto_mode |=> removal_lamp_o == $past(bl.short_on))
		else $error("Removal lamp not on short blink.");

	a_lamp_long_blink: assert property (st_reg.hs == HS_M2 && rem_auto_mode
		|=> removal_lamp_o == $past(bl.long_on))
		else $error("Removal lamp not on long blink.");

	a_handle_event: assert property (s_handle_open
		|=> st_reg.hs == HS_M5 && st_reg.evt[EVT_OPEN_BIT] && event_pend_o)
		else $error("Handle opening not reported.");

	a_quiesce_power: assert property (s_quiesce ##1 st_reg.hs == HS_M6
		|=> !payload_en_o)
		else $error("Payload power kept on after quiesce.");

	a_quiesced_event: assert property (st_reg.hs == HS_M6 && !payload_en_o && !pgood
		|=> st_reg.hs == HS_M1 && st_reg.evt[EVT_QUIES_BIT])
		else $error("Quiesced event missing after power removal.");

	a_reject_back: assert property (st_reg.hs == HS_M5 && !cmd_quies && cmd_rej
		|=> st_reg.hs == HS_M4 ##1 (!removal_lamp_o || !rem_auto_mode))
		else $error("Rejected request did not return to active.");

	a_boot_gate: assert property ($rose(run_op_o) |-> $past(st_reg.sum_ok, 2) && op_flag_o)
		else $error("Operational code started without valid checksum.");

	a_upgrade_hold: assert property (mgmt_rst_o |=> st_reg.boot == BT_TEST && !run_op_o)
		else $error("Controller ran during boot block upgrade.");

	a_oos_upgrade: assert property (st_reg.ctrl[CTRL_FWUP_BIT]
		&& st_reg.lamp[LAMP_OOS_LSB +: 3] == LM_AUTO |=> out_of_service_lamp_o)
		else $error("Out-of-service lamp dark during upgrade.");

	a_health_amber: assert property (fault && st_reg.lamp[LAMP_HLT_LSB +: 3] == LM_AUTO
		|=> health_amber_o && !health_green_o)
		else $error("Health lamp not amber on threshold.");

	a_link_follow: assert property (st_reg.link[LINK_N-1:0] == '0
		|=> link_lamp_o == $past(link_q))
		else $error("Link lamp does not follow link state.");

endmodule

/* test/hsl_rail_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Payload rail
// ------------------------------------------------------------------
module hsl_rail_model #(
	parameter int DLY = 40
) (
	input  wire logic clk_i,
	input  wire logic en_i,
	output logic      pgood_o
);
	logic [DLY-1:0] sh_reg = '0;
	// Power good trails the enable, so the rail takes a while to fall.
	always @(posedge clk_i) begin
		sh_reg <= {sh_reg[DLY-2:0], en_i};
	end
	assign pgood_o = sh_reg[DLY-1];
endmodule

/* test/hsl_top_tb.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Bench
// ------------------------------------------------------------------
module hsl_top_tb;
	import hsl_pkg::*;
	localparam int PER = 20;
	localparam int SON = 2;
	localparam int LON = 18;
	logic              clk_i, rst_i, cyc, stb, we, hnd_n, flt, st_ok, cv, cl;
	logic [7:0]        adr, cd;
	logic [31:0]       wdat, rd, dat_o;
	logic [LINK_N-1:0] lnk, llamp;
	logic              ack, pen, mrst, opf, run, evp, rl, ol, hg, ha, pg;
	int                error_cnt, tests_run;

	hsl_top #(.PERIOD_CYC_P(PER), .SHORT_ON_CYC_P(SON), .LONG_ON_CYC_P(LON)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .handle_switch_n_i(hnd_n),
		.payload_pgood_i(pg), .sensor_fault_i(flt), .link_up_i(lnk),
		.selftest_ok_i(st_ok), .code_valid_i(cv), .code_data_i(cd),
		.code_last_i(cl), .payload_en_o(pen), .mgmt_rst_o(mrst),
		.op_flag_o(opf), .run_op_o(run), .event_pend_o(evp),
		.removal_lamp_o(rl), .out_of_service_lamp_o(ol), .health_green_o(hg),
		.health_amber_o(ha), .link_lamp_o(llamp));

	hsl_rail_model i_rail (.clk_i(clk_i), .en_i(pen), .pgood_o(pg));

	// Clock at 250 MHz.
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic cycle; ack is sampled at the edge, so the hold ends exactly there.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) chk(32'h0, 32'h1);
	endtask

	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask

	// Any window of one period holds exactly the pattern's on-time.
	task automatic blinks(input int e);
		int c;
		c = 0;
		repeat (PER) begin
			@(posedge clk_i);
			// An unknown lamp level must never pass as dark.
			if (rl === 1'b1) begin
				c++;
			end else if (rl !== 1'b0) begin
				c += PER + 1;
			end
		end
		chk(c, e);
	endtask

	task automatic pause(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic test_done;
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Watchdog: the sequence needs well under a thousand cycles.
	initial begin
		pause(5000);
		error_cnt++;
		test_done;
	end

	// Main sequence.
	initial begin
		{cyc, stb, we, flt, st_ok, cv, cl, adr, cd, wdat, lnk} = '0;
		error_cnt = 0;
		tests_run = 0;
		hnd_n = 1'b1;
		rst_i = 1'b1;
		pause(6);
		rst_i <= 1'b0;
		rdm(ADR_INFO, 32'hFF, 32'h0A);
		rdm(8'h40, 32'hFFFFFFFF, 32'h0);
		pause(10);
		rdm(ADR_STAT, 32'h7, 32'h2);
		blinks(LON);
		bus(1'b1, ADR_CMD, 32'h1);
		pause(50);
		rdm(ADR_STAT, 32'hF, 32'hC);
		chk(pen, 1'b1);
		blinks(0);
		chk({hg, ha}, 2'b10);
		flt <= 1'b1;
		lnk <= 5'h15;
		pause(8);
		chk({hg, ha}, 2'b01);
		chk(llamp, 5'h15);
		flt <= 1'b0;
		$display("test active done");
		hnd_n <= 1'b0;
		pause(10);
		rdm(ADR_STAT, 32'h7, 32'h5);
		rdm(ADR_EVT, 32'h3, 32'h1);
		chk(evp, 1'b1);
		blinks(SON);
		bus(1'b1, ADR_CMD, 32'h4);
		pause(3);
		blinks(0);
		rdm(ADR_STAT, 32'h7, 32'h4);
		hnd_n <= 1'b1;
		pause(10);
		hnd_n <= 1'b0;
		pause(10);
		bus(1'b1, ADR_EVT, 32'h3);
		chk(evp, 1'b0);
		bus(1'b1, ADR_CMD, 32'h2);
		blinks(SON);
		pause(60);
		rdm(ADR_STAT, 32'hF, 32'h1);
		chk(pen, 1'b0);
		rdm(ADR_EVT, 32'h3, 32'h2);
		blinks(PER);
		$display("test removal done");
		bus(1'b1, ADR_LAMP, 32'h1);
		blinks(0);
		bus(1'b1, ADR_LAMP, 32'h524);
		blinks(LON);
		chk({ol, hg, ha}, 3'b101);
		rdm(ADR_LAMP, 32'hFFF, 32'h524);
		bus(1'b1, ADR_LAMP, 32'h0);
		bus(1'b1, ADR_LINK, 32'h0A1F);
		pause(3);
		chk(llamp, 5'h0A);
		pause(3);
		chk(ol, 1'b0);
		bus(1'b1, ADR_CTRL, 32'h1);
		pause(3);
		chk(ol, 1'b1);
		bus(1'b1, ADR_CTRL, 32'h0);
		$display("test lamps done");
		st_ok <= 1'b1;
		pause(3);
		chk(run, 1'b0);
		cv <= 1'b1;
		cd <= 8'h10;
		pause(1);
		cd <= 8'hF0;
		cl <= 1'b1;
		pause(1);
		cv <= 1'b0;
		cl <= 1'b0;
		pause(5);
		chk({opf, run}, 2'b11);
		bus(1'b1, ADR_CTRL, 32'h2);
		pause(3);
		chk({mrst, run}, 2'b10);
		// Releasing the hold restarts the boot; a bad code sum must not run.
		bus(1'b1, ADR_CTRL, 32'h0);
		pause(2);
		cv <= 1'b1;
		cl <= 1'b1;
		cd <= 8'h01;
		pause(1);
		cv <= 1'b0;
		cl <= 1'b0;
		pause(4);
		chk({opf, run}, 2'b10);
		rdm(ADR_STAT, 32'h70, 32'h50);
		$display("test boot done");
		// A reset in mid-run clears flags and events and returns to the inactive state.
		rst_i <= 1'b1;
		pause(6);
		rst_i <= 1'b0;
		pause(2);
		chk({pen, evp, mrst, opf, run}, 5'h00);
		pause(10);
		rdm(ADR_STAT, 32'hF, 32'h1);
		blinks(PER);
		$display("test reset done");
		test_done;
	end
endmodule
